// >>> hw/cbc_defines.vh
`ifndef CBC_DEFINES_VH
`define CBC_DEFINES_VH

// Register indices
`define CBC_IDX_OUT_ENABLE   8'h00
`define CBC_IDX_PLL_AMP      8'h01
`define CBC_IDX_SLEW         8'h02
`define CBC_IDX_FREQ_SEL     8'h03
`define CBC_IDX_RSVD_ONES    8'h04
`define CBC_IDX_REV_VENDOR   8'h05
`define CBC_IDX_DEV_CLASS    8'h06
`define CBC_IDX_READ_LEN     8'h07

// Field positions
`define CBC_POS_STRAP_HI     7
`define CBC_POS_STRAP_LO     6
`define CBC_POS_MODE_SW      5
`define CBC_POS_SW_MODE_HI   4
`define CBC_POS_SW_MODE_LO   3
`define CBC_POS_FREQ_EN      5
`define CBC_POS_RATE_HI      4
`define CBC_POS_RATE_LO      3
`define CBC_POS_FB_SLEW      0

// Writable bit masks, reserved bits read as shown by the fixed masks
`define CBC_MASK_PER_OUT     8'hDD
`define CBC_ONES_PLL_AMP     8'h04
`define CBC_ONES_FREQ_SEL    8'h06
`define CBC_MASK_READ_LEN    8'h1F

// Reset values
`define CBC_RST_OUT_ENABLE   8'hDD
`define CBC_RST_SLEW         8'hDD
`define CBC_RST_AMP          2'b10
`define CBC_RST_READ_LEN     5'h08
`define CBC_RSVD_VALUE       8'hFF

// Identity values, arbitrary
`define CBC_REVISION_CODE    4'h3
`define CBC_MAKER_CODE       4'h5
`define CBC_CLASS_CODE       2'b01
`define CBC_DEVICE_CODE      6'h2A

// Serial bus address, arbitrary
`define CBC_SLAVE_ADDR       7'h2A

`endif

// >>> hw/cbc_config_regs.v
// Behaviour
// R01: A cleared per-output enable bit holds that output Low/Low whatever its enable pin says.
// R02: Bits 7:6 of the loop-mode register read back the mode latched from the straps at power-up.
// R03: Bit 5 picks the mode source: 0 uses the strap value, 1 uses the software bits 4:3.
// R04: Software mode bits 4:3 have no effect while bit 5 is 0, and both reset to 0.
// R05: Amplitude bits 1:0 select 0.6, 0.7, 0.8 or 0.9 V swing and reset to 10.
// R06: Slew bits 7,6,4,3,2,0 drive outputs 5..0, 1 is fast, bits 5 and 1 are reserved, all reset fast.
// R07: Bit 5 of the frequency register enables software frequency change and resets to 0.
// R08: Rate bits 4:3 have no effect unless bit 5 is 1, and both reset to 0.
// R09: Bit 0 of the frequency register sets the feedback output slew, 1 fast, reset fast.
// R10: The reserved register at index 4 always reads all ones.
// R11: Index 5 is read-only with the revision code in the upper and maker code in the lower nibble.
// R12: Index 6 is read-only with a two-bit class code in 7:6 and a six-bit device code in 5:0.
// R13: Bits 4:0 of index 7 set the block read length, reset 8, bits 7:5 reserved.
// R14: A block write carries address, start index, byte count and data, each byte acknowledged.
// R15: A block read sends the byte count first, then data, until the host answers not-acknowledge.
// R16: Writes to read-only and reserved bits are ignored and their read values stay fixed.
`include "cbc_defines.vh"

module cbc_config_regs (
	// Clock, reset, enable
	input  wire       mclk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	// Serial management bus
	input  wire       scl_i,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe_n_o,
	// Pins
	input  wire [1:0] strap_mode_i,
	input  wire [5:0] oe_n_pin_i,
	// Control outputs to the clock path
	output reg  [1:0] pll_mode_o,
	output reg  [1:0] amplitude_o,
	output reg  [5:0] slew_fast_o,
	output reg        fb_slew_fast_o,
	output reg        freq_sw_en_o,
	output reg  [1:0] freq_sel_o,
	output reg  [5:0] diff_out_en_o,
	output reg  [4:0] read_len_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detect
	reg  [1:0] scl_sy_r;
	reg  [1:0] sda_sy_r;
	reg        scl_d_r;
	reg        sda_d_r;
	reg  [1:0] strap_s1_r;
	reg  [1:0] strap_s2_r;
	reg  [5:0] oe_s1_r;
	reg  [5:0] oe_s2_r;

	always @(posedge mclk_i) begin
		if (rst_i) begin
			scl_sy_r   <= 2'b11;
			sda_sy_r   <= 2'b11;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
			oe_s1_r    <= 6'h00;
			oe_s2_r    <= 6'h00;
		end else if (ce_i) begin
			scl_sy_r   <= {scl_sy_r[0], scl_i};
			sda_sy_r   <= {sda_sy_r[0], sda_i};
			scl_d_r    <= scl_sy_r[1];
			sda_d_r    <= sda_sy_r[1];
			oe_s1_r    <= oe_n_pin_i;
			oe_s2_r    <= oe_s1_r;
		end
	end

	// Strap synchroniser runs through reset so the latch sees settled pins
	always @(posedge mclk_i) begin
		if (ce_i) begin
			strap_s1_r <= strap_mode_i;
			strap_s2_r <= strap_s1_r; // [R02]
		end
	end

	wire scl_s    = scl_sy_r[1];
	wire sda_s    = sda_sy_r[1];
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	reg  [7:0] oe_bits_r;
	reg        strap_done_r;
	reg  [1:0] strap_lat_r;
	reg        mode_sw_r;
	reg  [1:0] sw_mode_r;
	reg  [1:0] amp_r;
	reg  [7:0] slew_r;
	reg        freq_en_r;
	reg  [1:0] rate_r;
	reg        fb_slew_r;
	reg  [4:0] rlen_r;

	// Read mux, reserved bits fixed
	function [7:0] rd_byte;
		input [7:0] idx;
		begin
			case (idx)
				`CBC_IDX_OUT_ENABLE: rd_byte = oe_bits_r & `CBC_MASK_PER_OUT;
				`CBC_IDX_PLL_AMP:    rd_byte = {strap_lat_r, mode_sw_r, sw_mode_r, 1'b0, amp_r}
				                         | `CBC_ONES_PLL_AMP; // [R02]
				`CBC_IDX_SLEW:       rd_byte = slew_r & `CBC_MASK_PER_OUT;
				`CBC_IDX_FREQ_SEL:   rd_byte = {2'b00, freq_en_r, rate_r, 2'b00, fb_slew_r}
				                         | `CBC_ONES_FREQ_SEL;
				`CBC_IDX_RSVD_ONES:  rd_byte = `CBC_RSVD_VALUE; // [R10]
				`CBC_IDX_REV_VENDOR: rd_byte = {`CBC_REVISION_CODE, `CBC_MAKER_CODE}; // [R11]
				`CBC_IDX_DEV_CLASS:  rd_byte = {`CBC_CLASS_CODE, `CBC_DEVICE_CODE}; // [R12]
				`CBC_IDX_READ_LEN:   rd_byte = {3'b000, rlen_r};
				default:             rd_byte = 8'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Serial slave state machine
	localparam ST_IDLE  = 3'd0;
	localparam ST_RX    = 3'd1;
	localparam ST_RXACK = 3'd2;
	localparam ST_TX    = 3'd3;
	localparam ST_TXACK = 3'd4;

	localparam PH_ADDR  = 2'd0;
	localparam PH_INDEX = 2'd1;
	localparam PH_COUNT = 2'd2;
	localparam PH_DATA  = 2'd3;

	reg  [2:0] state_r;
	reg  [1:0] phase_r;
	reg  [3:0] bit_cnt_r;
	reg  [7:0] shift_r;
	reg  [7:0] index_r;
	reg  [7:0] wleft_r;
	reg        rd_dir_r;
	reg        first_r;
	reg        drive_r;

	wire [7:0] rx_byte = shift_r;
	wire [7:0] tx_next = first_r ? {3'b000, rlen_r} : rd_byte(index_r);

	always @(posedge mclk_i) begin
		if (rst_i) begin
			state_r      <= ST_IDLE;
			phase_r      <= PH_ADDR;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			index_r      <= 8'h00;
			wleft_r      <= 8'h00;
			rd_dir_r     <= 1'b0;
			first_r      <= 1'b0;
			drive_r      <= 1'b1;
			oe_bits_r    <= `CBC_RST_OUT_ENABLE;
			strap_done_r <= 1'b0;
			strap_lat_r  <= 2'b00;
			mode_sw_r    <= 1'b0;
			sw_mode_r    <= 2'b00; // [R04]
			amp_r        <= `CBC_RST_AMP; // [R05]
			slew_r       <= `CBC_RST_SLEW; // [R06]
			freq_en_r    <= 1'b0; // [R07]
			rate_r       <= 2'b00; // [R08]
			fb_slew_r    <= 1'b1; // [R09]
			rlen_r       <= `CBC_RST_READ_LEN; // [R13]
		end else if (ce_i) begin
			// Straps caught once after reset release
			if (!strap_done_r) begin
				strap_done_r <= 1'b1;
				strap_lat_r  <= strap_s2_r; // [R02]
			end
			if (stop_ev) begin
				state_r <= ST_IDLE;
				drive_r <= 1'b1;
			end else if (start_ev) begin
				state_r   <= ST_RX;
				phase_r   <= PH_ADDR;
				bit_cnt_r <= 4'h0;
				drive_r   <= 1'b1;
			end else begin
				case (state_r)
					ST_RX: begin
						if (scl_rise) begin
							shift_r   <= {shift_r[6:0], sda_s};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == 4'h8) begin
							bit_cnt_r <= 4'h0;
							state_r   <= ST_RXACK;
							drive_r   <= 1'b0; // [R14]
							case (phase_r)
								PH_ADDR: begin
									if (rx_byte[7:1] != `CBC_SLAVE_ADDR) begin
										state_r <= ST_IDLE;
										drive_r <= 1'b1;
									end
									rd_dir_r <= rx_byte[0];
									first_r  <= 1'b1;
									phase_r  <= rx_byte[0] ? PH_DATA : PH_INDEX;
								end
								PH_INDEX: begin
									index_r <= rx_byte;
									phase_r <= PH_COUNT;
								end
								PH_COUNT: begin
									wleft_r <= rx_byte;
									phase_r <= PH_DATA;
								end
								default: begin
									if (wleft_r != 8'h00) begin
										wleft_r <= wleft_r - 8'h01;
										index_r <= index_r + 8'h01;
										case (index_r) // [R16]
											`CBC_IDX_OUT_ENABLE: oe_bits_r <= rx_byte & `CBC_MASK_PER_OUT;
											`CBC_IDX_PLL_AMP: begin
												mode_sw_r <= rx_byte[`CBC_POS_MODE_SW];
												sw_mode_r <= rx_byte[`CBC_POS_SW_MODE_HI:`CBC_POS_SW_MODE_LO];
												amp_r     <= rx_byte[1:0]; // [R05]
											end
											`CBC_IDX_SLEW: slew_r <= rx_byte & `CBC_MASK_PER_OUT; // [R06]
											`CBC_IDX_FREQ_SEL: begin
												freq_en_r <= rx_byte[`CBC_POS_FREQ_EN]; // [R07]
												rate_r    <= rx_byte[`CBC_POS_RATE_HI:`CBC_POS_RATE_LO];
												fb_slew_r <= rx_byte[`CBC_POS_FB_SLEW]; // [R09]
											end
											`CBC_IDX_READ_LEN: rlen_r <= rx_byte[4:0]; // [R13]
											default: ;
										endcase
									end
								end
							endcase
						end
					end
					ST_RXACK: begin
						if (scl_fall) begin
							if (phase_r == PH_DATA && rd_dir_r) begin
								// Count byte goes out first
								state_r   <= ST_TX; // [R15]
								drive_r   <= tx_next[7];
								shift_r   <= {tx_next[6:0], 1'b0};
								bit_cnt_r <= 4'h1;
								first_r   <= 1'b0;
							end else begin
								state_r <= ST_RX;
								drive_r <= 1'b1;
							end
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (bit_cnt_r == 4'h8) begin
								state_r <= ST_TXACK;
								drive_r <= 1'b1;
							end else begin
								drive_r   <= shift_r[7];
								shift_r   <= {shift_r[6:0], 1'b0};
								bit_cnt_r <= bit_cnt_r + 4'h1;
							end
						end
					end
					ST_TXACK: begin
						if (scl_rise && sda_s) begin
							state_r <= ST_IDLE; // [R15]
						end else if (scl_fall) begin
							state_r   <= ST_TX;
							drive_r   <= tx_next[7];
							shift_r   <= {tx_next[6:0], 1'b0};
							bit_cnt_r <= 4'h1;
							index_r   <= index_r + 8'h01;
						end
					end
					default: begin
						state_r <= ST_IDLE;
						drive_r <= 1'b1;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	wire [5:0] oe_per_out   = {oe_bits_r[7], oe_bits_r[6], oe_bits_r[4],
	                           oe_bits_r[3], oe_bits_r[2], oe_bits_r[0]};
	wire [5:0] slew_per_out = {slew_r[7], slew_r[6], slew_r[4],
	                           slew_r[3], slew_r[2], slew_r[0]};

	always @(posedge mclk_i) begin
		if (rst_i) begin
			sda_o          <= 1'b0;
			sda_oe_n_o     <= 1'b1;
			pll_mode_o     <= 2'b00;
			amplitude_o    <= `CBC_RST_AMP;
			slew_fast_o    <= 6'h3F;
			fb_slew_fast_o <= 1'b1;
			freq_sw_en_o   <= 1'b0;
			freq_sel_o     <= 2'b00;
			read_len_o     <= `CBC_RST_READ_LEN;
		end else if (ce_i) begin
			sda_o          <= 1'b0;
			sda_oe_n_o     <= drive_r;
			pll_mode_o     <= mode_sw_r ? sw_mode_r : strap_lat_r; // [R03] [R04]
			amplitude_o    <= amp_r; // [R05]
			slew_fast_o    <= slew_per_out; // [R06]
			fb_slew_fast_o <= fb_slew_r; // [R09]
			freq_sw_en_o   <= freq_en_r; // [R07]
			freq_sel_o     <= freq_en_r ? rate_r : 2'b00; // [R08]
			read_len_o     <= rlen_r; // [R13]
		end
	end

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_out_en
			always @(posedge mclk_i) begin
				if (rst_i) begin
					diff_out_en_o[g] <= 1'b0;
				end else if (ce_i) begin
					diff_out_en_o[g] <= oe_per_out[g] & ~oe_s2_r[g]; // [R01]
				end
			end
		end
	endgenerate

endmodule // cbc_config_regs

// >>> bench/cbc_config_regs_chk.sv
module cbc_config_regs_chk (
	input wire       mclk_i,
	input wire       rst_i,
	input wire       scl_i,
	input wire       sda_o,
	input wire       sda_oe_n_o,
	input wire [5:0] oe_n_pin_i,
	input wire [5:0] diff_out_en_o,
	input wire [1:0] amplitude_o,
	input wire [5:0] slew_fast_o,
	input wire       fb_slew_fast_o,
	input wire       freq_sw_en_o,
	input wire [1:0] freq_sel_o,
	input wire [4:0] read_len_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Settings move only while the device acknowledges a byte
	sequence ack_phase;
		!sda_oe_n_o && !scl_i;
	endsequence
	rst_vals_a: assert property ($fell(rst_i) |-> amplitude_o == 2'h2 &&
		slew_fast_o == 6'h3F && fb_slew_fast_o && read_len_o == 5'h08 && !freq_sw_en_o)
		else $error("outputs not at reset values");
	freq_gate_a: assert property (!freq_sw_en_o |-> freq_sel_o == 2'h0)
		else $error("rate choice applied while disabled");
	oe_pin_a: assert property ((diff_out_en_o & $past(oe_n_pin_i, 2) &
		$past(oe_n_pin_i, 3) & $past(oe_n_pin_i, 4)) == 6'h00) else $error("output runs, pin high");
	sda_edge_a: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("data line moved with bus clock high");
	amp_write_a: assert property ($changed(amplitude_o) |-> ack_phase)
		else $error("amplitude moved outside a write");
	slew_write_a: assert property ($changed(slew_fast_o) |-> ack_phase)
		else $error("slew moved outside a write");
	freq_write_a: assert property ($changed({freq_sw_en_o, freq_sel_o, fb_slew_fast_o}) |->
		ack_phase) else $error("frequency control moved outside a write");
	len_write_a: assert property ($changed(read_len_o) |-> ack_phase)
		else $error("read length moved outside a write");
	drive_low_a: assert property (sda_o == 1'b0)
		else $error("data line driven high");
endmodule // cbc_config_regs_chk

bind cbc_config_regs cbc_config_regs_chk u_cbc_config_regs_chk (.mclk_i, .rst_i, .scl_i, .sda_o,
	.sda_oe_n_o, .oe_n_pin_i, .amplitude_o, .slew_fast_o, .fb_slew_fast_o, .freq_sw_en_o,
	.freq_sel_o, .read_len_o, .diff_out_en_o);

// >>> bench/cbc_host_model.sv
module cbc_host_model (
	input  wire  mclk_i,
	input  wire  sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// Start or repeated start: data falls while the clock is high
	task automatic start_c();
		sda_low_o <= 1'b0;
		tick(5);
		scl_o <= 1'b1;
		tick(10);
		sda_low_o <= 1'b1;
		tick(10);
		scl_o <= 1'b0;
		tick(5);
	endtask
	task automatic stop_c();
		sda_low_o <= 1'b1;
		tick(5);
		scl_o <= 1'b1;
		tick(10);
		sda_low_o <= 1'b0;
		tick(10);
	endtask
	// Nine bits MSB first; a 1 releases the line so the device can answer
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			sda_low_o <= !d[i];
			tick(8);
			scl_o <= 1'b1;
			tick(10);
			q[i] = sda_i;
			scl_o <= 1'b0;
			tick(5);
		end
	endtask
endmodule // cbc_host_model

// >>> bench/cbc_config_regs_tb_top.sv
`include "cbc_defines.vh"
module cbc_config_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] STRAP = 2'h2;
	logic       mclk_i = 0;
	logic       rst_i = 1;
	logic [5:0] oe_n_pin_i = 6'h00;
	logic       scl, sda_low;
	wire        sda_o, sda_oe_n_o, fb_slew_fast_o, freq_sw_en_o;
	wire  [1:0] pll_mode_o, amplitude_o, freq_sel_o;
	wire  [5:0] slew_fast_o, diff_out_en_o;
	wire  [4:0] read_len_o;
	wire        sda_w = !(sda_low || (!sda_oe_n_o && !sda_o));
	int         bad_count = 0, comparisons = 0, cycles = 0;
	logic [7:0] len = 8'h08;
	logic [8:0] q;
	logic [7:0] rv [8] = '{{STRAP, 6'h06}, 8'hDD, 8'h07, 8'hFF,
		{`CBC_REVISION_CODE, `CBC_MAKER_CODE}, {`CBC_CLASS_CODE, `CBC_DEVICE_CODE}, 8'h08, 8'h00};
	always #5 mclk_i = ~mclk_i;
	cbc_config_regs u_cbc_config_regs (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .strap_mode_i(STRAP),
		.oe_n_pin_i(oe_n_pin_i), .pll_mode_o(pll_mode_o), .amplitude_o(amplitude_o),
		.slew_fast_o(slew_fast_o), .fb_slew_fast_o(fb_slew_fast_o), .freq_sw_en_o(freq_sw_en_o),
		.freq_sel_o(freq_sel_o), .diff_out_en_o(diff_out_en_o), .read_len_o(read_len_o));
	cbc_host_model u_cbc_host_model (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
		.sda_low_o(sda_low));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic hdr(input logic [7:0] idx);
		u_cbc_host_model.start_c();
		u_cbc_host_model.xfer({`CBC_SLAVE_ADDR, 2'h1}, q);
		chk("address ack", q[0], 1'b0);
		u_cbc_host_model.xfer({idx, 1'b1}, q);
		chk("index ack", q[0], 1'b0);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] n, input logic [23:0] d);
		hdr(idx);
		u_cbc_host_model.xfer({n, 1'b1}, q);
		for (int i = 0; i < n; i++) begin
			u_cbc_host_model.xfer({d[23-8*i -: 8], 1'b1}, q);
			chk("data ack", q[0], 1'b0);
		end
		u_cbc_host_model.stop_c();
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		hdr(idx);
		u_cbc_host_model.start_c();
		u_cbc_host_model.xfer({`CBC_SLAVE_ADDR, 2'h3}, q);
		chk("read ack", q[0], 1'b0);
		u_cbc_host_model.xfer(9'h1FE, q);
		chk("count byte", q[8:1], len);
		u_cbc_host_model.xfer(9'h1FF, q);
		chk("register", q[8:1], exp);
		u_cbc_host_model.stop_c();
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 90000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		chk("loop mode", pll_mode_o, STRAP);
		foreach (rv[i]) rd(8'(i + 1), rv[i]);
		u_cbc_host_model.start_c();
		u_cbc_host_model.xfer({7'h2B, 2'h1}, q);
		chk("foreign ack", q[0], 1'b1);
		u_cbc_host_model.stop_c();
		wr(8'h04, 8'h03, 24'h000000);
		for (int i = 3; i < 6; i++) rd(8'(i + 1), rv[i]);
		wr(8'h01, 8'h01, 24'h180000);
		chk("loop mode", pll_mode_o, STRAP);
		rd(8'h01, {STRAP, 6'h1C});
		for (int a = 0; a < 4; a++) begin
			wr(8'h01, 8'h01, {3'h1, a[1:0], 1'b0, a[1:0], 16'h0000});
			chk("loop mode", pll_mode_o, a[1:0]);
			chk("amplitude", amplitude_o, a[1:0]);
			rd(8'h01, {STRAP, 1'b1, a[1:0], 1'b1, a[1:0]});
		end
		wr(8'h02, 8'h02, 24'hA3D800);
		chk("slew", slew_fast_o, 6'h21);
		chk("rate", {freq_sw_en_o, freq_sel_o, fb_slew_fast_o}, 8'h00);
		rd(8'h02, 8'h81);
		rd(8'h03, 8'h1E);
		wr(8'h03, 8'h01, 24'h310000);
		chk("rate", {freq_sw_en_o, freq_sel_o, fb_slew_fast_o}, 8'h0D);
		oe_n_pin_i <= 6'h02;
		wr(8'h00, 8'h01, 24'h5C0000);
		chk("running outputs", diff_out_en_o, 6'h1C);
		wr(8'h07, 8'h01, 24'hFF0000);
		len = 8'h1F;
		chk("read length", read_len_o, 5'h1F);
		rd(8'h07, 8'h1F);
		complete_run();
	end
endmodule // cbc_config_regs_tb_top
